// file: cdr_cfg_pkg.sv
/*
 * Constants, field layouts and carrier types for the per-channel
 * recovery-loop configuration register bank of a quad retimer.
 * Assumes a serial programming front end elsewhere that turns frames
 * into single-cycle register read and write requests on this clock.
 */
// Operation
// R01 - Loop state bits 7:6 code 00b keeps the loop powered and in path (default), 01b powered but bypassed.
// R02 - Loop state code 10b powers the loop down with no signal through, 11b powers it down and bypasses.
// R03 - Bit 5 of the loop register set selects the alternating one-zero pattern lock mode.
// R04 - Bit 5 clear, the default, selects normal mode expecting about half of bits to transition.
// R05 - Bits 3:0 pick the rate divider, codes 0 to 8 giving 1, 2, 4, 8, 12, 16, 24, 32, 48, default 0.
// R06 - The comparison divider register is eight bits wide and resets to 40h.
// R07 - The comparison ratio equals the value written, 1 to 255, and software must not write zero.
// R08 - Output bits 7:6 pick the driver swing, default 10b, and 00b powers both buffers down.
// R09 - Output bit 3 set inverts the retimed data polarity, clear by default.
// R10 - Output bit 0 set inverts the recovered clock polarity, clear by default.
// R11 - Output bit 2 enables the data driver, default one, and clear powers it down.
// R12 - Output bit 1 enables the clock driver, default zero, and clear powers it down.
// R13 - Each channel owns a sixteen-byte page whose upper address nibble is the channel index plus four.
// R14 - After a rate change software pulses the channel soft reset, which keeps the setup registers.
// R15 - Every read-write bit, reserved ones too, reads back the last written value or its default.
package cdr_cfg_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int          CHAN_COUNT      = 4;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  PAGE_FIRST      = 4'h4;
    localparam logic [3:0]  OFS_LOOP_RATE   = 4'h1;
    localparam logic [3:0]  OFS_COMPARE     = 4'h2;
    localparam logic [3:0]  OFS_OUTPUT      = 4'h3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_LOOP_RATE   = 8'h00;
    localparam logic [7:0]  RST_COMPARE     = 8'h40;
    localparam logic [7:0]  RST_OUTPUT      = 8'h84;
    localparam logic [7:0]  RD_IDLE         = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          LOOP_STATE_HI   = 7;
    localparam int          LOOP_STATE_LO   = 6;
    localparam int          ALT_PAT_BIT     = 5;
    localparam int          RATE_HI         = 3;
    localparam int          RATE_LO         = 0;
    localparam int          SWING_HI        = 7;
    localparam int          SWING_LO        = 6;
    localparam int          DATA_INV_BIT    = 3;
    localparam int          DATA_EN_BIT     = 2;
    localparam int          CLK_EN_BIT      = 1;
    localparam int          CLK_INV_BIT     = 0;

    // ----------------------------------------------------------------
    // Field codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  LOOP_ACTIVE     = 2'h0;
    localparam logic [1:0]  LOOP_BYPASS     = 2'h1;
    localparam logic [1:0]  LOOP_OFF        = 2'h2;
    localparam logic [1:0]  LOOP_OFF_BYPASS = 2'h3;
    localparam logic [1:0]  SWING_OFF       = 2'h0;
    localparam logic [7:0]  COMPARE_MIN     = 8'h01;

    // Register select one-hot positions
    localparam int          SEL_LOOP        = 0;
    localparam int          SEL_COMPARE     = 1;
    localparam int          SEL_OUTPUT      = 2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                wr_en;
        logic                rd_en;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wr_data;
    } reg_req_t;

    typedef struct packed {
        logic                loop_powered;
        logic                loop_in_path;
        logic                signal_through;
        logic                alternating_pattern_mode;
        logic [3:0]          line_rate_divider;
        logic [5:0]          line_rate_ratio;
        logic [7:0]          compare_divider_value;
        logic [1:0]          out_swing;
        logic                data_drv_on;
        logic                clk_drv_on;
        logic                data_invert;
        logic                clk_invert;
    } chan_ctrl_t;

endpackage : cdr_cfg_pkg

// file: cdr_channel_regs.sv
/*
 * Storage for one channel: loop/rate, comparison divider and output
 * driver registers. Assumes one-hot write selects from the page decoder.
 */
`timescale 1ns/1ns
module cdr_channel_regs
    import cdr_cfg_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic [2:0]        i_wr_sel,
    input  wire logic [DATA_W-1:0] i_wr_data,
    output logic      [DATA_W-1:0] o_loop_rate,
    output logic      [DATA_W-1:0] o_compare,
    output logic      [DATA_W-1:0] o_output
);

    // ----------------------------------------------------------------
    // Whole bytes kept, reserved bits included
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_loop_rate <= RST_LOOP_RATE;                  // R01
        else if (i_wr_sel[SEL_LOOP])
            o_loop_rate <= i_wr_data;                      // R15
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_compare <= RST_COMPARE;                      // R06
        else if (i_wr_sel[SEL_COMPARE])
            o_compare <= i_wr_data;                        // R15
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_output <= RST_OUTPUT;                        // R08
        else if (i_wr_sel[SEL_OUTPUT])
            o_output <= i_wr_data;                         // R15
    end

endmodule : cdr_channel_regs

// file: cdr_channel_config_regs.sv
/*
 * Register bank for the four recovery-loop channels of a quad retimer,
 * with decoded per-channel controls for the analog side.
 * Assumes the serial programming front end runs on i_clk and presents
 * at most one request per cycle; asynchronous reset is synchronised here.
 * Offsets outside the three registers of each page belong to other
 * blocks; this bank ignores their writes and reads them back as zero.
 */
`timescale 1ns/1ns
module cdr_channel_config_regs
    import cdr_cfg_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire reg_req_t          i_req,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_rd_valid,
    output chan_ctrl_t [CHAN_COUNT-1:0] o_chan_ctrl
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic page_hit(input logic [ADDR_W-1:0] addr, input int idx);
        logic [3:0] page;
        page = PAGE_FIRST + 4'(idx);
        return addr[7:4] == page;                          // R13
    endfunction : page_hit

    function automatic logic [2:0] reg_select(input logic [ADDR_W-1:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        case (addr[3:0])
            OFS_LOOP_RATE: sel[SEL_LOOP]    = 1'b1;
            OFS_COMPARE:   sel[SEL_COMPARE] = 1'b1;
            OFS_OUTPUT:    sel[SEL_OUTPUT]  = 1'b1;
            default:       sel = 3'h0;
        endcase
        return sel;
    endfunction : reg_select

    // Codes past 1000b are undefined; they fall back to the largest ratio
    function automatic logic [5:0] rate_ratio(input logic [3:0] code);
        logic [5:0] r;
        case (code)                                        // R05
            4'h0:    r = 6'h01;
            4'h1:    r = 6'h02;
            4'h2:    r = 6'h04;
            4'h3:    r = 6'h08;
            4'h4:    r = 6'h0C;
            4'h5:    r = 6'h10;
            4'h6:    r = 6'h18;
            4'h7:    r = 6'h20;
            default: r = 6'h30;
        endcase
        return r;
    endfunction : rate_ratio

    // Swing code 00b powers both buffers down whatever the enables say
    function automatic logic swing_on(input logic [1:0] swing);
        return swing != SWING_OFF;                         // R08
    endfunction : swing_on

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Every flop behind the synchronizer leaves reset on the same edge, two edges after release
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ----------------------------------------------------------------
    // Per-channel storage and decoding
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] loop_rate [CHAN_COUNT];
    logic [DATA_W-1:0] compare   [CHAN_COUNT];
    logic [DATA_W-1:0] outctl    [CHAN_COUNT];
    chan_ctrl_t        next_ctrl [CHAN_COUNT];
    logic [2:0]        sel_now;

    assign sel_now = reg_select(i_req.addr);

    genvar ch;
    generate
        for (ch = 0; ch < CHAN_COUNT; ch++)
        begin : g_chan
            logic [2:0] wr_sel;

            // --------------------------------------------------------
            // Write select and storage
            // --------------------------------------------------------
            // Pages never overlap, so at most one channel takes a write
            assign wr_sel = (i_req.wr_en && page_hit(i_req.addr, ch)) ? sel_now : 3'h0; // R13

            cdr_channel_regs cdr_channel_regs_i (
                .i_clk       (i_clk),
                .i_rst_n     (rst_n),
                .i_wr_sel    (wr_sel),
                .i_wr_data   (i_req.wr_data),
                .o_loop_rate (loop_rate[ch]),
                .o_compare   (compare[ch]),
                .o_output    (outctl[ch])
            );

            // --------------------------------------------------------
            // Control decode
            // --------------------------------------------------------
            always_comb
            begin
                logic [1:0] state;
                logic [1:0] swing;
                state = loop_rate[ch][LOOP_STATE_HI:LOOP_STATE_LO];
                swing = outctl[ch][SWING_HI:SWING_LO];
                next_ctrl[ch] = '0;
                case (state)
                    LOOP_ACTIVE:                               // R01
                    begin
                        next_ctrl[ch].loop_powered   = 1'b1;
                        next_ctrl[ch].loop_in_path   = 1'b1;
                        next_ctrl[ch].signal_through = 1'b1;
                    end
                    LOOP_BYPASS:                               // R01
                    begin
                        next_ctrl[ch].loop_powered   = 1'b1;
                        next_ctrl[ch].signal_through = 1'b1;
                    end
                    LOOP_OFF_BYPASS:                           // R02
                        next_ctrl[ch].signal_through = 1'b1;
                    default:                                   // R02
                        next_ctrl[ch].signal_through = 1'b0;
                endcase
                next_ctrl[ch].alternating_pattern_mode = loop_rate[ch][ALT_PAT_BIT]; // R03
                next_ctrl[ch].line_rate_divider = loop_rate[ch][RATE_HI:RATE_LO];  // R05
                next_ctrl[ch].line_rate_ratio   = rate_ratio(loop_rate[ch][RATE_HI:RATE_LO]);
                // A forbidden zero is held at the minimum so the loop never stalls
                next_ctrl[ch].compare_divider_value =
                    (compare[ch] == 8'h00) ? COMPARE_MIN : compare[ch];            // R07
                next_ctrl[ch].out_swing   = swing;                                  // R08
                next_ctrl[ch].data_drv_on = outctl[ch][DATA_EN_BIT] && swing_on(swing); // R11
                next_ctrl[ch].clk_drv_on  = outctl[ch][CLK_EN_BIT] && swing_on(swing);  // R12
                next_ctrl[ch].data_invert = outctl[ch][DATA_INV_BIT];               // R09
                next_ctrl[ch].clk_invert  = outctl[ch][CLK_INV_BIT];                // R10
            end

            // --------------------------------------------------------
            // Control stage
            // --------------------------------------------------------
            // Controls are registered so the analog side sees glitch-free levels
            always_ff @(posedge i_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    o_chan_ctrl[ch].loop_powered             <= 1'b1;   // R01
                    o_chan_ctrl[ch].loop_in_path             <= 1'b1;
                    o_chan_ctrl[ch].signal_through           <= 1'b1;
                    o_chan_ctrl[ch].alternating_pattern_mode <= 1'b0;   // R04
                    o_chan_ctrl[ch].line_rate_divider        <= RST_LOOP_RATE[RATE_HI:RATE_LO];
                    o_chan_ctrl[ch].line_rate_ratio          <= 6'h01;
                    o_chan_ctrl[ch].compare_divider_value    <= RST_COMPARE;
                    o_chan_ctrl[ch].out_swing                <= RST_OUTPUT[SWING_HI:SWING_LO];
                    o_chan_ctrl[ch].data_drv_on              <= RST_OUTPUT[DATA_EN_BIT];  // R11
                    o_chan_ctrl[ch].clk_drv_on               <= RST_OUTPUT[CLK_EN_BIT];   // R12
                    o_chan_ctrl[ch].data_invert              <= RST_OUTPUT[DATA_INV_BIT];
                    o_chan_ctrl[ch].clk_invert               <= RST_OUTPUT[CLK_INV_BIT];
                end
                else
                    o_chan_ctrl[ch] <= next_ctrl[ch];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped offsets read as the idle value
    logic [DATA_W-1:0] next_rd_data;

    always_comb
    begin
        next_rd_data = RD_IDLE;
        for (int i = 0; i < CHAN_COUNT; i++)
        begin
            if (page_hit(i_req.addr, i))
            begin
                case (sel_now)
                    3'h1:    next_rd_data = loop_rate[i];   // R15
                    3'h2:    next_rd_data = compare[i];     // R15
                    3'h4:    next_rd_data = outctl[i];      // R15
                    default: next_rd_data = RD_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_rd_data <= RD_IDLE;
        else if (i_req.rd_en)
            o_rd_data <= next_rd_data;
    end

    // Valid follows every read, mapped or not, so software never stalls
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_rd_valid <= 1'b0;
        else
            o_rd_valid <= i_req.rd_en;
    end

endmodule : cdr_channel_config_regs

// file: cdr_channel_config_regs_checker.sv
/*
 * Concurrent checks on the ports of the channel configuration bank.
 * Assumes it is bound to the top module and that requests wait for
 * the internal reset copy to release.
 */
`timescale 1ns/1ns
module cdr_channel_config_regs_checker
    import cdr_cfg_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    input  wire reg_req_t                    i_req,
    input  wire logic [DATA_W-1:0]           o_rd_data,
    input  wire logic                        o_rd_valid,
    input  wire chan_ctrl_t [CHAN_COUNT-1:0] o_chan_ctrl
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire logic wr_loop = i_req.wr_en && i_req.addr == 8'h51;
    wire logic wr_out  = i_req.wr_en && i_req.addr == 8'h73;
    wire logic mapped  = i_req.addr[7:4] inside {[4:7]} && i_req.addr[3:0] inside {[1:3]};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RD_VALID: assert property (o_rd_valid == $past(i_req.rd_en))
        else $error("read valid not one cycle after read");
    AST_RD_HOLD: assert property (!i_req.rd_en |=> $stable(o_rd_data))
        else $error("read data moved without a read");
    AST_RD_UNMAPPED: assert property (i_req.rd_en && !mapped |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_LOOP_STATE: assert property (wr_loop |-> ##2 {o_chan_ctrl[1].loop_powered,
        o_chan_ctrl[1].loop_in_path, o_chan_ctrl[1].signal_through} == {!$past(i_req.wr_data[7], 2),
        $past(i_req.wr_data[7:6], 2) == 2'h0, $past(i_req.wr_data[7:6], 2) != 2'h2})
        else $error("loop state decode wrong");
    AST_ALT_MODE: assert property (wr_loop |-> ##2
        o_chan_ctrl[1].alternating_pattern_mode == $past(i_req.wr_data[5], 2))
        else $error("pattern mode wrong");
    AST_RATE_FIELD: assert property (wr_loop |-> ##2
        o_chan_ctrl[1].line_rate_divider == $past(i_req.wr_data[3:0], 2))
        else $error("rate divider wrong");
    AST_COMPARE_NONZERO: assert property (o_chan_ctrl[2].compare_divider_value != 8'h00)
        else $error("compare ratio zero");
    AST_SWING_OFF: assert property (o_chan_ctrl[3].out_swing == 2'h0
        |-> !o_chan_ctrl[3].data_drv_on && !o_chan_ctrl[3].clk_drv_on)
        else $error("driver on with swing off");
    AST_DRV_EN: assert property (wr_out |-> ##2 o_chan_ctrl[3].data_drv_on ==
        ($past(i_req.wr_data[2], 2) && $past(i_req.wr_data[7:6], 2) != 2'h0))
        else $error("data driver enable wrong");
    AST_INVERT: assert property (wr_out |-> ##2 {o_chan_ctrl[3].data_invert,
        o_chan_ctrl[3].clk_invert} == {$past(i_req.wr_data[3], 2), $past(i_req.wr_data[0], 2)})
        else $error("polarity flags wrong");
endmodule : cdr_channel_config_regs_checker

bind cdr_channel_config_regs cdr_channel_config_regs_checker cdr_channel_config_regs_checker_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_chan_ctrl(o_chan_ctrl));

// file: cdr_channel_config_regs_tb.sv
/*
 * Self-checking bench for the channel configuration bank.
 * Assumes the checker is bound separately; drives requests directly.
 */
`timescale 1ns/1ns
module cdr_channel_config_regs_tb
    import cdr_cfg_pkg::*;
();
    logic                        i_clk;
    logic                        i_reset_n;
    reg_req_t                    i_req;
    logic [DATA_W-1:0]           o_rd_data;
    logic                        o_rd_valid;
    chan_ctrl_t [CHAN_COUNT-1:0] o_chan_ctrl;
    int                          n_fail;
    int                          compares;
    logic [5:0]                  ratio_tab [0:9] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C,
                                                     6'h10, 6'h18, 6'h20, 6'h30, 6'h30};

    cdr_channel_config_regs cdr_channel_config_regs_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_req(i_req), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_chan_ctrl(o_chan_ctrl));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] pg(input int ch, input logic [3:0] ofs);
        return {4'(ch + 4), ofs};
    endfunction : pg
    function automatic logic [7:0] outv(input int ch);
        return {o_chan_ctrl[ch].out_swing, 2'h0, o_chan_ctrl[ch].data_invert,
                o_chan_ctrl[ch].data_drv_on, o_chan_ctrl[ch].clk_drv_on, o_chan_ctrl[ch].clk_invert};
    endfunction : outv
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: d};
        @(posedge i_clk);
        i_req.wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: 8'h00};
        @(posedge i_clk);
        i_req.rd_en <= 1'b0;
        #1;
        chk("rd_valid", 8'h01, {7'h00, o_rd_valid});
        chk("rd_data", exp, o_rd_data);
    endtask : rd
    task automatic do_reset;
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask : do_reset

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        for (int ch = 0; ch < CHAN_COUNT; ch++)
        begin
            rd(pg(ch, OFS_LOOP_RATE), 8'h00);
            rd(pg(ch, OFS_COMPARE), 8'h40);
            rd(pg(ch, OFS_OUTPUT), 8'h84);
            chk("cmp_val", 8'h40, o_chan_ctrl[ch].compare_divider_value);
            chk("ratio", 8'h01, {2'h0, o_chan_ctrl[ch].line_rate_ratio});
            chk("loop", 8'h07, {4'h0, o_chan_ctrl[ch].alternating_pattern_mode,
                o_chan_ctrl[ch].loop_powered, o_chan_ctrl[ch].loop_in_path,
                o_chan_ctrl[ch].signal_through});
            chk("rate", 8'h00, {4'h0, o_chan_ctrl[ch].line_rate_divider});
            chk("outv", 8'h84, outv(ch));
        end
    endtask : t_defaults
    task automatic t_loop_rate;
        logic [7:0] d;
        for (int k = 0; k < 10; k++)
        begin
            d = {2'(k), k[0], k[2], 4'(k)};
            wr(pg(1, OFS_LOOP_RATE), d);
            // Soft reset sits at offset 0, outside this bank, and must keep the setup
            wr(pg(1, 4'h0), 8'h80);
            wr(pg(1, 4'h0), 8'h00);
            rd(pg(1, OFS_LOOP_RATE), d);
            chk("rate", {4'h0, d[3:0]}, {4'h0, o_chan_ctrl[1].line_rate_divider});
            chk("ratio", {2'h0, ratio_tab[k]}, {2'h0, o_chan_ctrl[1].line_rate_ratio});
            chk("loop", {5'h00, !d[7], d[7:6] == 2'h0, d[7:6] != 2'h2}, {5'h00,
                o_chan_ctrl[1].loop_powered, o_chan_ctrl[1].loop_in_path, o_chan_ctrl[1].signal_through});
            chk("alt", {7'h00, d[5]}, {7'h00, o_chan_ctrl[1].alternating_pattern_mode});
        end
    endtask : t_loop_rate
    task automatic t_compare;
        logic [7:0] v [0:2] = '{8'hFF, 8'h01, 8'h00};
        for (int k = 0; k < 3; k++)
        begin
            wr(pg(2, OFS_COMPARE), v[k]);
            rd(pg(2, OFS_COMPARE), v[k]);
            chk("cmp_val", (v[k] == 8'h00) ? 8'h01 : v[k], o_chan_ctrl[2].compare_divider_value);
        end
    endtask : t_compare
    task automatic t_output;
        logic [7:0] v [0:2] = '{8'h06, 8'h7F, 8'hC9};
        logic [7:0] e [0:2] = '{8'h00, 8'h4F, 8'hC9};
        for (int k = 0; k < 3; k++)
        begin
            wr(pg(3, OFS_OUTPUT), v[k]);
            rd(pg(3, OFS_OUTPUT), v[k]);
            chk("outv", e[k], outv(3));
        end
    endtask : t_output
    task automatic t_unmapped;
        logic [7:0] a [0:3] = '{8'h30, 8'h44, 8'h80, 8'h40};
        for (int k = 0; k < 4; k++)
            wr(a[k], 8'hFF);
        for (int k = 0; k < 4; k++)
            rd(a[k], 8'h00);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h40);
    endtask : t_unmapped

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial
    begin
        #50000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        i_reset_n = 1'b0;
        i_req = '0;
        n_fail = 0;
        compares = 0;
        do_reset();
        t_defaults();
        t_loop_rate();
        t_compare();
        t_output();
        t_unmapped();
        // Mid-run reset must bring every written channel back to defaults
        do_reset();
        t_defaults();
        tally_and_finish();
    end
endmodule : cdr_channel_config_regs_tb
